// ==== prpu_regs.svh ====
// Register offsets, field positions and reset values of the page relocation unit
`ifndef PRPU_REGS_SVH
`define PRPU_REGS_SVH

// ****************************************
// Register map (byte addresses)
// ****************************************
`define PRPU_OFS_KBASE 8'h00
`define PRPU_OFS_KDESC 8'h20
`define PRPU_OFS_UBASE 8'h40
`define PRPU_OFS_UDESC 8'h60
`define PRPU_OFS_CTRL 8'h80
`define PRPU_OFS_STAT 8'h84

// ****************************************
// Field layout
// ****************************************
`define PRPU_BASE_MASK 16'h0fff
`define PRPU_DESC_MASK 16'h7f0e
`define PRPU_KEY_MSB 2
`define PRPU_KEY_LSB 1
`define PRPU_ED_BIT 3
`define PRPU_PLF_MSB 14
`define PRPU_PLF_LSB 8
`define PRPU_CTRL_EN_BIT 0
`define PRPU_STAT_CAUSE_MSB 3
`define PRPU_STAT_PAGE_LSB 4
`define PRPU_STAT_MODE_LSB 7

// ****************************************
// Encodings
// ****************************************
`define PRPU_MODE_KERNEL 2'h0
`define PRPU_MODE_USER 2'h3
`define PRPU_ACF_NONRES 2'h0
`define PRPU_ACF_RO 2'h1
`define PRPU_ACF_UNUSED 2'h2
`define PRPU_ACF_RW 2'h3
`define PRPU_IO_PAGE 3'h7
`define PRPU_IO_EXT 2'h3

// ****************************************
// Reset values
// ****************************************
`define PRPU_CTRL_RST 1'h0
`define PRPU_CAUSE_RST 4'h0

`endif

// ==== prpu_pkg.sv ====
// Types shared by the page relocation unit
package prpu_pkg;

  typedef enum logic [3:0] {
    PRPU_IDLE = 4'h1,
    PRPU_LOOK = 4'h2,
    PRPU_BUS = 4'h4,
    PRPU_ACK = 4'h8
  } prpu_state_e;

  typedef struct packed {
    logic [15:0] va;
    logic is_write;
    logic [1:0] cur_mode;
    logic [1:0] prev_mode;
    logic use_prev;
  } prpu_core_req_s;

  typedef struct packed {
    logic [17:0] pa;
    logic is_write;
  } prpu_mem_req_s;

  // Cause bits: mode, length, read-only, non-resident
  typedef logic [3:0] prpu_cause_t;

endpackage

// ==== prpu_page_mem.sv ====
// Storage of the sixteen page register pairs, registered read port
`timescale 1ns/1ps
module prpu_page_mem (
  input wire logic mclk,
  input wire logic [3:0] rd_addr,
  output logic [31:0] rd_data,
  input wire logic wr_en,
  input wire logic [3:0] wr_addr,
  input wire logic [31:0] wr_data,
  input wire logic [31:0] wr_mask
);

  logic [31:0] mem_q [0:15];

  // Array holds no reset; software loads every pair before enabling
  always_ff @(posedge mclk)
  begin
    if (wr_en)
    begin
      mem_q[wr_addr] <= (mem_q[wr_addr] & ~wr_mask) | (wr_data & wr_mask);
    end
    rd_data <= mem_q[rd_addr];
  end

endmodule

// ==== prpu_top.sv ====
// Paged address relocation and access protection unit
//
// Contract
// - With relocation on, core byte address is virtual and yields 18-bit physical.
// - Virtual space is eight 4K-word pages, each translated by its own pair.
// - Page length is 1 to 128 blocks of 32 words.
// - Relocated page starts fall on 32-word boundaries.
// - References beyond the allocated length of a short page are refused.
// - Separate kernel and user sets of eight register pairs each.
// - Each page carries a 2-bit key checked on every reference; the code checks it only while relocation is on.
// - Key 0: non-resident, any reference aborts.
// - Key 2: reads and fetches pass, writes abort.
// - Key 6: reads and writes both pass.
// - Set chosen by current mode field, or previous mode when asked.
// - Mode 00 selects kernel set; modes 01 and 10 abort every reference; the code aborts them only while relocation is on.
// - Several pages may map the same physical region with own keys.
// - Mode 11 selects the user set.
// - Aborted references never reach the memory bus.
// - Base register holds 12-bit base field; bits 15 to 12 unused.
// - Top three virtual address bits pick the pair in the set.
//
// The register offsets and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ps
`include "prpu_regs.svh"
module prpu_top (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic core_req,
  input wire prpu_pkg::prpu_core_req_s core_in,
  output logic core_ready,
  output logic mem_req,
  output prpu_pkg::prpu_mem_req_s mem_out,
  output logic abort,
  output prpu_pkg::prpu_cause_t abort_cause,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  import prpu_pkg::*;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [1:0] pick_mode(input prpu_core_req_s r);
    pick_mode = r.use_prev ? r.prev_mode : r.cur_mode;
  endfunction

  function automatic logic [3:0] pair_index(input logic [1:0] mode, input logic [15:0] va);
    pair_index = {mode == `PRPU_MODE_USER, va[15:13]};
  endfunction

  function automatic logic [17:0] pa_calc(input logic [11:0] base, input logic [15:0] va);
    logic [17:0] sum;
    sum = {base, 6'h00} + {5'h00, va[12:0]};
    pa_calc = sum;
  endfunction

  // ****************************************
  // State
  // ****************************************
  prpu_state_e state_q, state_d;
  prpu_core_req_s hold_q;
  logic ctrl_en_q;
  prpu_cause_t sticky_q;
  logic [2:0] last_page_q;
  logic [1:0] last_mode_q;
  logic core_ready_q;
  logic mem_req_q;
  prpu_mem_req_s mem_out_q;
  logic abort_q;
  prpu_cause_t abort_cause_q;
  logic [31:0] rdata_q;
  logic wait_q;

  // ****************************************
  // Bus decode
  // ****************************************
  logic in_idle, in_look, in_bus, in_ack;
  logic bus_req, page_hit, desc_hit, ctrl_hit, stat_hit;
  logic [3:0] bus_index;
  logic [15:0] lane16;
  logic [15:0] wd16;
  logic [31:0] mem_wdata, mem_wmask;
  logic mem_wen;
  logic [3:0] mem_raddr;
  logic [31:0] mem_rdata;
  logic take_core, take_bus;

  assign in_idle = (state_q == PRPU_IDLE);
  assign in_look = (state_q == PRPU_LOOK);
  assign in_bus = (state_q == PRPU_BUS);
  assign in_ack = (state_q == PRPU_ACK);
  assign bus_req = avs_read | avs_write;
  assign page_hit = ~avs_address[7] & (avs_address[1:0] == 2'h0);
  assign desc_hit = avs_address[5];
  assign ctrl_hit = (avs_address == `PRPU_OFS_CTRL);
  assign stat_hit = (avs_address == `PRPU_OFS_STAT);
  assign bus_index = {avs_address[6], avs_address[4:2]};
  assign lane16 = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wd16 = avs_writedata[15:0];
  // Unused descriptor and base bits never stored, so they read back zero
  assign mem_wdata = {wd16 & `PRPU_DESC_MASK, wd16 & `PRPU_BASE_MASK};
  assign mem_wmask = desc_hit ? {lane16, 16'h0000} : {16'h0000, lane16};
  // Write lands at the edge where waitrequest is seen low
  assign mem_wen = in_ack & avs_write & page_hit;
  // Core lookups win the read port; bus waits behind them
  assign take_core = in_idle & core_req;
  assign take_bus = in_idle & ~core_req & bus_req;
  assign mem_raddr = core_req ? pair_index(pick_mode(core_in), core_in.va) : bus_index;

  prpu_page_mem prpu_page_mem_i (
    .mclk(mclk),
    .rd_addr(mem_raddr),
    .rd_data(mem_rdata),
    .wr_en(mem_wen),
    .wr_addr(bus_index),
    .wr_data(mem_wdata),
    .wr_mask(mem_wmask)
  );

  // ****************************************
  // Translation and protection
  // ****************************************
  logic [1:0] hold_mode;
  logic [15:0] desc_w;
  logic [11:0] base_f;
  logic [1:0] key_f;
  logic [6:0] plf_f;
  logic [6:0] blk_f;
  logic ed_f;
  logic mode_bad, len_bad, ro_bad, nonres_bad;
  prpu_cause_t cause_now;
  logic abort_now;
  logic [17:0] pa_direct, pa_now;

  assign hold_mode = pick_mode(hold_q);
  assign desc_w = mem_rdata[31:16];
  assign base_f = mem_rdata[11:0];
  assign key_f = desc_w[`PRPU_KEY_MSB:`PRPU_KEY_LSB];
  assign plf_f = desc_w[`PRPU_PLF_MSB:`PRPU_PLF_LSB];
  assign ed_f = desc_w[`PRPU_ED_BIT];
  assign blk_f = hold_q.va[12:6];
  // Kernel 00 and user 11 only; the other two codes abort
  assign mode_bad = (hold_mode != `PRPU_MODE_KERNEL) & (hold_mode != `PRPU_MODE_USER);
  // Upward pages allow blocks up to the length field, downward from it
  assign len_bad = ed_f ? (blk_f < plf_f) : (blk_f > plf_f);
  assign nonres_bad = (key_f == `PRPU_ACF_NONRES) | (key_f == `PRPU_ACF_UNUSED);
  assign ro_bad = (key_f == `PRPU_ACF_RO) & hold_q.is_write;
  // Key 6 raises no bit here, so both directions pass
  assign cause_now = {mode_bad, len_bad, ro_bad, nonres_bad};
  assign abort_now = ctrl_en_q & (|cause_now);
  // Top page maps to the I/O window while relocation is off
  assign pa_direct = {(hold_q.va[15:13] == `PRPU_IO_PAGE) ? `PRPU_IO_EXT : 2'h0, hold_q.va};
  // No uniqueness check: aliased pages simply share physical space
  assign pa_now = ctrl_en_q ? pa_calc(base_f, hold_q.va) : pa_direct;

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      PRPU_IDLE:
      begin
        if (take_core)
        begin
          state_d = PRPU_LOOK;
        end
        else if (take_bus)
        begin
          state_d = avs_read ? PRPU_BUS : PRPU_ACK;
        end
      end
      PRPU_LOOK:
      begin
        state_d = PRPU_IDLE;
      end
      PRPU_BUS:
      begin
        state_d = PRPU_ACK;
      end
      PRPU_ACK:
      begin
        state_d = PRPU_IDLE;
      end
      default:
      begin
        state_d = PRPU_IDLE;
      end
    endcase
  end

  // ****************************************
  // Register read mux and status update
  // ****************************************
  logic [31:0] page_rd, rd_d;
  logic [31:0] stat_word;
  logic stat_clr_wr;
  prpu_cause_t sticky_set, sticky_d;
  logic wait_d;

  assign page_rd = desc_hit ? {16'h0000, mem_rdata[31:16]} : {16'h0000, mem_rdata[15:0]};
  assign stat_word = {23'h000000, last_mode_q, last_page_q, sticky_q};
  assign rd_d = page_hit ? page_rd :
                ctrl_hit ? {31'h00000000, ctrl_en_q} :
                stat_hit ? stat_word : 32'h00000000;
  assign stat_clr_wr = in_ack & avs_write & stat_hit & avs_byteenable[0];
  assign sticky_set = (in_look & abort_now) ? cause_now : `PRPU_CAUSE_RST;
  // A cause raised in the clearing cycle survives the clear
  assign sticky_d = (sticky_q & ~(stat_clr_wr ? avs_writedata[3:0] : 4'h0)) | sticky_set;
  // Low for exactly one cycle: after a read's data is loaded or a write's decode
  assign wait_d = ~(in_bus | take_bus & avs_write);

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      state_q <= PRPU_IDLE;
      hold_q <= '0;
      wait_q <= 1'b1;
      rdata_q <= 32'h00000000;
    end
    else
    begin
      state_q <= state_d;
      wait_q <= wait_d;
      if (take_core)
      begin
        hold_q <= core_in;
      end
      if (in_bus)
      begin
        rdata_q <= rd_d;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      ctrl_en_q <= `PRPU_CTRL_RST;
      sticky_q <= `PRPU_CAUSE_RST;
      last_page_q <= 3'h0;
      last_mode_q <= 2'h0;
    end
    else
    begin
      sticky_q <= sticky_d;
      if (in_ack & avs_write & ctrl_hit & avs_byteenable[0])
      begin
        ctrl_en_q <= avs_writedata[`PRPU_CTRL_EN_BIT];
      end
      if (in_look & abort_now)
      begin
        last_page_q <= hold_q.va[15:13];
        last_mode_q <= hold_mode;
      end
    end
  end

  // ****************************************
  // Core and memory side outputs
  // ****************************************
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      core_ready_q <= 1'b0;
      mem_req_q <= 1'b0;
      mem_out_q <= '0;
      abort_q <= 1'b0;
      abort_cause_q <= `PRPU_CAUSE_RST;
    end
    else
    begin
      core_ready_q <= (state_d == PRPU_IDLE);
      // Aborted references are stopped here and never issued
      mem_req_q <= in_look & ~abort_now;
      abort_q <= in_look & abort_now;
      if (in_look)
      begin
        mem_out_q <= '{pa: pa_now, is_write: hold_q.is_write};
        abort_cause_q <= abort_now ? cause_now : `PRPU_CAUSE_RST;
      end
    end
  end

  assign core_ready = core_ready_q;
  assign mem_req = mem_req_q;
  assign mem_out = mem_out_q;
  assign abort = abort_q;
  assign abort_cause = abort_cause_q;
  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;

endmodule

// ==== prpu_mem_model.sv ====
// Memory bus partner that counts the references it receives
`timescale 1ns/1ps
module prpu_mem_model (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic mem_req,
  input wire prpu_pkg::prpu_mem_req_s mem_out,
  output logic [7:0] n_refs_q
);
  import prpu_pkg::*;
  // Only references that reach the bus are counted, so refused ones show up as no change
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      n_refs_q <= 8'h00;
    else if (mem_req)
      n_refs_q <= n_refs_q + 8'h01;
  end
endmodule

// ==== prpu_top_sva.sv ====
// Checker of the page relocation unit ports
`timescale 1ns/1ps
`include "prpu_regs.svh"
module prpu_top_sva (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic core_req,
  input wire prpu_pkg::prpu_core_req_s core_in,
  input wire logic core_ready,
  input wire logic mem_req,
  input wire prpu_pkg::prpu_mem_req_s mem_out,
  input wire logic abort,
  input wire prpu_pkg::prpu_cause_t abort_cause,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  import prpu_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  logic en_q;
  wire take = core_req && core_ready;
  wire [1:0] mode_u = core_in.use_prev ? core_in.prev_mode : core_in.cur_mode;
  // Shadow of the enable bit, so relocation-off behaviour can be judged
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      en_q <= 1'b0;
    else if (avs_write && !avs_waitrequest && avs_address == `PRPU_OFS_CTRL && avs_byteenable[0])
      en_q <= avs_writedata[0];
  end
  a_ready_drop: assert property (take |=> !core_ready) else $error("ready held");
  a_answer_once: assert property (take |-> ##2 (mem_req != abort)) else $error("no answer");
  a_abort_nomem: assert property (abort |-> !mem_req) else $error("abort on bus");
  a_abort_cause: assert property (abort |-> abort_cause != 4'h0) else $error("no cause");
  a_good_clear: assert property (mem_req |-> abort_cause == 4'h0) else $error("stale cause");
  a_pa_direct: assert property (take && !en_q |-> ##2 mem_req && mem_out.pa ==
    {{2{$past(core_in.va[15:13], 2) == 3'h7}}, $past(core_in.va, 2)}) else $error("direct pa");
  a_mode_bad: assert property (take && en_q && (mode_u == 2'h1 || mode_u == 2'h2) |->
    ##2 abort && abort_cause[3]) else $error("bad mode passed");
  a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("wait low");
  a_wait_req: assert property (!avs_waitrequest |-> avs_read || avs_write) else $error("no req");
  a_read_upper: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:16] == 16'h0)
    else $error("upper half");
endmodule
bind prpu_top prpu_top_sva prpu_top_sva_i (.mclk(mclk), .rstn(rstn), .core_req(core_req),
  .core_in(core_in), .core_ready(core_ready), .mem_req(mem_req), .mem_out(mem_out),
  .abort(abort), .abort_cause(abort_cause), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

// ==== test_paged_relocation_protection_unit.sv ====
// Self-checking bench of the page relocation unit
`timescale 1ns/1ps
`include "prpu_regs.svh"
module test_paged_relocation_protection_unit;
  import prpu_pkg::*;
  logic mclk, rstn, core_req, core_ready, mem_req, abort, avs_read, avs_write, avs_waitrequest;
  prpu_core_req_s core_in;
  prpu_mem_req_s mem_out;
  prpu_cause_t abort_cause;
  logic [7:0] avs_address, n_refs_q;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0] avs_byteenable;
  logic [11:0] kb [8];
  logic [11:0] ub [8];
  logic [1:0] kk [8];
  int n_errors = 0;
  int checks_done = 0;
  prpu_top prpu_top_i (.mclk(mclk), .rstn(rstn), .core_req(core_req), .core_in(core_in),
    .core_ready(core_ready), .mem_req(mem_req), .mem_out(mem_out), .abort(abort),
    .abort_cause(abort_cause), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  prpu_mem_model prpu_mem_model_i (.mclk(mclk), .rstn(rstn), .mem_req(mem_req),
    .mem_out(mem_out), .n_refs_q(n_refs_q));
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task end_sim;
    if (n_errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e)
    begin
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
      n_errors++;
    end
  endtask
  // Request is held until the edge that samples waitrequest low
  task wait_ack(output logic [31:0] d);
    int i;
    i = 0;
    do
    begin
      @(posedge mclk);
      i++;
    end
    while (avs_waitrequest !== 1'b0 && i < 50);
    d = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0)
    begin
      n_errors++;
      end_sim;
    end
  endtask
  task bw(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    wait_ack(x);
  endtask
  task br(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_read <= 1'b1;
    wait_ack(d);
  endtask
  function logic [17:0] epa(input logic [11:0] b, input logic [15:0] va);
    return {b, 6'h00} + {5'h00, va[12:0]};
  endfunction
  task trans(input logic [15:0] va, input logic wr, input logic [1:0] cm, input logic [1:0] pm,
    input logic up, input logic ab, input logic [17:0] pa, input prpu_cause_t ca);
    logic [7:0] n0;
    int i;
    i = 0;
    while (core_ready !== 1'b1 && i < 20)
    begin
      @(posedge mclk);
      i++;
    end
    if (core_ready !== 1'b1)
    begin
      n_errors++;
      end_sim;
    end
    n0 = n_refs_q;
    @(posedge mclk);
    core_req <= 1'b1;
    core_in <= {va, wr, cm, pm, up};
    @(posedge mclk);
    core_req <= 1'b0;
    @(posedge mclk);
    #1;
    chk("answer", {30'h0, ab, ~ab}, {30'h0, abort, mem_req});
    if (ab)
      chk("cause", {28'h0, ca}, {28'h0, abort_cause});
    else
    begin
      chk("pa", {14'h0, pa}, {14'h0, mem_out.pa});
      chk("dir", {31'h0, wr}, {31'h0, mem_out.is_write});
    end
    @(posedge mclk);
    #1;
    chk("refs", {24'h0, n0 + {7'h00, ~ab}}, {24'h0, n_refs_q});
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    rstn = 1'b0;
    core_req = 1'b0;
    core_in = '0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    for (int i = 0; i < 8; i++)
    begin
      kb[i] = 12'h040 + 12'(i) * 12'h011;
      ub[i] = 12'h800 + 12'(i);
    end
    kb[6] = kb[0];
    kb[7] = 12'hfff;
    kk = '{2'h3, 2'h1, 2'h0, 2'h2, 2'h3, 2'h3, 2'h1, 2'h3};
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    bw(`PRPU_OFS_KBASE, 32'hffffffff);
    br(`PRPU_OFS_KBASE, rd);
    chk("base", 32'h00000fff, rd);
    bw(`PRPU_OFS_KDESC, 32'hffffffff);
    br(`PRPU_OFS_KDESC, rd);
    chk("desc", 32'h00007f0e, rd);
    bw(8'hf0, 32'h12345678);
    br(8'hf0, rd);
    chk("unmapped", 32'h0, rd);
    trans(16'he000, 0, 0, 0, 0, 0, 18'h3e000, 4'h0);
    trans(16'h1234, 1, 1, 0, 0, 0, 18'h01234, 4'h0);
    for (int i = 0; i < 8; i++)
    begin
      bw(`PRPU_OFS_KBASE + 8'(4 * i), {20'h0, kb[i]});
      bw(`PRPU_OFS_KDESC + 8'(4 * i), {17'h0, (i == 5) ? 7'h01 : 7'h7f, 5'h00, kk[i], 1'b0});
      bw(`PRPU_OFS_UBASE + 8'(4 * i), {20'h0, ub[i]});
      bw(`PRPU_OFS_UDESC + 8'(4 * i), 32'h00007f06);
    end
    bw(`PRPU_OFS_CTRL, 32'h1);
    br(`PRPU_OFS_CTRL, rd);
    chk("ctrl", 32'h1, rd);
    trans(16'h0042, 0, 0, 0, 0, 0, epa(kb[0], 16'h0042), 4'h0);
    trans(16'h0100, 1, 0, 0, 0, 0, epa(kb[0], 16'h0100), 4'h0);
    trans(16'h2010, 0, 0, 0, 0, 0, epa(kb[1], 16'h2010), 4'h0);
    trans(16'h2010, 1, 0, 0, 0, 1, 18'h0, 4'h2);
    trans(16'h4000, 0, 0, 0, 0, 1, 18'h0, 4'h1);
    trans(16'h6000, 0, 0, 0, 0, 1, 18'h0, 4'h1);
    trans(16'ha07e, 0, 0, 0, 0, 0, epa(kb[5], 16'ha07e), 4'h0);
    trans(16'ha080, 0, 0, 0, 0, 1, 18'h0, 4'h4);
    trans(16'hc042, 0, 0, 0, 0, 0, epa(kb[0], 16'h0042), 4'h0);
    trans(16'hc042, 1, 0, 0, 0, 1, 18'h0, 4'h2);
    trans(16'hffff, 1, 0, 0, 0, 0, epa(12'hfff, 16'hffff), 4'h0);
    trans(16'h0042, 0, 3, 0, 0, 0, epa(ub[0], 16'h0042), 4'h0);
    trans(16'he000, 1, 3, 0, 0, 0, epa(ub[7], 16'he000), 4'h0);
    trans(16'h0042, 0, 3, 0, 1, 0, epa(kb[0], 16'h0042), 4'h0);
    trans(16'h0042, 0, 0, 3, 1, 0, epa(ub[0], 16'h0042), 4'h0);
    trans(16'h0042, 0, 1, 0, 0, 1, 18'h0, 4'h8);
    trans(16'h0042, 0, 2, 0, 0, 1, 18'h0, 4'h8);
    br(`PRPU_OFS_STAT, rd);
    chk("status", 32'h0000010f, rd);
    bw(`PRPU_OFS_STAT, 32'h0000000f);
    br(`PRPU_OFS_STAT, rd);
    chk("status_clr", 32'h00000100, rd);
    end_sim;
  end
endmodule
